// ===== qpc_core.sv
// Core sequencer, pipeline, ALU and register file
//
// Contract
// - Clock divided by four into phases
// - Pointer increments phase one, latch phase four
// - Fetch overlaps execute, one per cycle
// - Pointer-changing instructions take two cycles
// - Latched opcode executed phases two to four
// - Operand read phase two, write phase four
// - Separate twelve-bit program bus
// - Eight-bit ALU, add sub shift logic
// - Accumulator plus file or literal operands
// - Accumulator has no file address
// - Carry, half-carry, zero flags updated
// - Special registers mapped, direct and indirect
// - Seven special, twenty-five general registers
// - Larger variant adds sixteen banked registers
// - Second bank aliases 20h-2Fh, distinct above
// - General registers direct or via pointer
// - Two bits select four oscillator modes
// - Crystal modes accept external clock input
// - Serial programming uses data, clock pins
`timescale 1ns/100ps
module qpc_core
   import qpc_pkg::*;
#(
   parameter bit LARGE_MEM = 1'b1
)(
   input  wire logic              clk_i,
   input  wire logic              reset_i,
   output logic      [IPTR_W-1:0] prog_addr_o,
   input  wire logic [OPC_W-1:0]  prog_data_i,
   input  wire logic [1:0]        osc_mode_select_bits_i,
   input  wire logic              prog_mode_i,
   input  wire logic [5:0]        io_pins_i,
   output logic      [5:0]        io_pins_o,
   output logic      [5:0]        io_pins_oe_n_o,
   output logic                   prog_data_pin_o,
   output logic                   prog_clock_pin_o,
   output logic                   crystal_ext_clk_ok_o,
   output logic      [1:0]        phase_o,
   output logic      [DATA_W-1:0] accum_o,
   output logic      [DATA_W-1:0] core_flags_o
);
   // ****************************************
   // Phase sequencer and fetch
   // ****************************************
   qpc_phase_e        phase_ff, nxt_phase;
   logic [IPTR_W-1:0] iptr_ff, nxt_iptr;
   logic [OPC_W-1:0]  fetch_ff, nxt_fetch;
   logic [OPC_W-1:0]  opcode_latch_ff, nxt_opcode_latch;
   logic              flush_ff, nxt_flush;
   logic              branch;
   logic [IPTR_W-1:0] branch_tgt;

   always_comb begin
      unique case (phase_ff)
         PHASE_ONE:   nxt_phase = PHASE_TWO;
         PHASE_TWO:   nxt_phase = PHASE_THREE;
         PHASE_THREE: nxt_phase = PHASE_FOUR;
         PHASE_FOUR:  nxt_phase = PHASE_ONE;
      endcase
      nxt_iptr         = iptr_ff;
      nxt_fetch        = fetch_ff;
      nxt_opcode_latch = opcode_latch_ff;
      nxt_flush        = flush_ff;
      if (phase_ff == PHASE_ONE) begin
         nxt_iptr         = iptr_ff + 1'b1;
         // Previously fetched word enters execution; flushed word becomes no-op
         nxt_opcode_latch = flush_ff ? NOP_WORD : fetch_ff;
         nxt_flush        = 1'b0;
      end
      if (phase_ff == PHASE_FOUR) begin
         nxt_fetch = prog_data_i;
         if (branch) begin
            // Land one short so the phase-one increment fetches the target itself
            nxt_iptr  = branch_tgt - 1'b1;
            nxt_flush = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         phase_ff        <= PHASE_ONE;
         iptr_ff         <= IPTR_RST;
         fetch_ff        <= NOP_WORD;
         opcode_latch_ff <= NOP_WORD;
         flush_ff        <= 1'b1;
      end else begin
         phase_ff        <= nxt_phase;
         iptr_ff         <= nxt_iptr;
         fetch_ff        <= nxt_fetch;
         opcode_latch_ff <= nxt_opcode_latch;
         flush_ff        <= nxt_flush;
      end
   end

   // ****************************************
   // Register file
   // ****************************************
   logic [DATA_W-1:0] gpr_mem [GPR_WORDS];
   logic [DATA_W-1:0] accum_ff, nxt_accum;
   logic [DATA_W-1:0] flags_ff, nxt_flags;
   logic [DATA_W-1:0] fsp_ff, nxt_fsp;
   logic [DATA_W-1:0] trim_ff, nxt_trim;
   logic [DATA_W-1:0] timer_ff, nxt_timer;
   logic [5:0]        io_ff, nxt_io;
   logic [DATA_W-1:0] operand_ff, nxt_operand;

   // Map a file address to a flat general register index, with banking
   function automatic logic [5:0] gpr_index(input logic [4:0] a, input logic [7:0] fsp);
      logic bank;
      bank = LARGE_MEM && (fsp[FSP_BANK_LSB+1:FSP_BANK_LSB] == 2'h1);
      if (a < ADDR_BANKED || !bank)
         gpr_index = {1'b0, a} - {1'b0, ADDR_GPR_FIRST};
      else
         gpr_index = {1'b0, a} + BANK_OFFSET - {1'b0, ADDR_GPR_FIRST};
   endfunction

   logic [4:0]        file_addr;
   logic [DATA_W-1:0] file_rd;
   always_comb begin
      file_addr = opcode_latch_ff[4:0];
      // Indirect port substitutes the pointer; reading the port through itself gives zero
      if (file_addr == ADDR_INDIRECT)
         file_addr = fsp_ff[4:0];
      unique case (file_addr)
         ADDR_INDIRECT: file_rd = '0;
         ADDR_TIMER:    file_rd = timer_ff;
         ADDR_IPTR_LOW: file_rd = iptr_ff[DATA_W-1:0];
         ADDR_FLAGS:    file_rd = flags_ff;
         ADDR_FSP:      file_rd = fsp_ff;
         ADDR_OSC_TRIM: file_rd = trim_ff;
         ADDR_IO_PINS:  file_rd = {2'h0, io_pins_i};
         default:       file_rd = gpr_mem[gpr_index(file_addr, fsp_ff)];
      endcase
   end

   // ****************************************
   // Decode and ALU
   // ****************************************
   logic [DATA_W-1:0] lit, res;
   logic [DATA_W:0]   sum;
   logic [4:0]        nib;
   logic              wr_file, wr_acc, upd_z, upd_c, upd_h;
   always_comb begin
      lit     = opcode_latch_ff[DATA_W-1:0];
      res     = accum_ff;
      sum     = '0;
      nib     = '0;
      wr_file = 1'b0;
      wr_acc  = 1'b0;
      upd_z   = 1'b0;
      upd_c   = 1'b0;
      upd_h   = 1'b0;
      branch     = 1'b0;
      branch_tgt = {1'b0, lit};
      unique case (opcode_latch_ff[11:8])
         4'h0, 4'h1, 4'h2, 4'h3: begin
            // File-register forms: one or two operands, result to accumulator or file register
            unique case (opcode_latch_ff[9:6])
               4'h1: begin res = 8'h00; upd_z = 1'b1; end
               4'h2: begin
                  sum = {1'b0, operand_ff} + {1'b0, ~accum_ff} + 9'h001;
                  nib = {1'b0, operand_ff[3:0]} + {1'b0, ~accum_ff[3:0]} + 5'h01;
                  res = sum[DATA_W-1:0]; upd_z = 1'b1; upd_c = 1'b1; upd_h = 1'b1;
               end
               4'h4: begin res = accum_ff | operand_ff; upd_z = 1'b1; end
               4'h5: begin res = accum_ff & operand_ff; upd_z = 1'b1; end
               4'h6: begin res = accum_ff ^ operand_ff; upd_z = 1'b1; end
               4'h7: begin
                  sum = {1'b0, operand_ff} + {1'b0, accum_ff};
                  nib = {1'b0, operand_ff[3:0]} + {1'b0, accum_ff[3:0]};
                  res = sum[DATA_W-1:0]; upd_z = 1'b1; upd_c = 1'b1; upd_h = 1'b1;
               end
               4'h8: begin res = operand_ff; upd_z = 1'b1; end
               4'h9: begin res = ~operand_ff; upd_z = 1'b1; end
               4'hc: begin
                  res = {flags_ff[FLAG_CARRY], operand_ff[7:1]};
                  sum = {operand_ff[0], 8'h00}; upd_c = 1'b1;
               end
               4'hd: begin
                  res = {operand_ff[6:0], flags_ff[FLAG_CARRY]};
                  sum = {operand_ff[7], 8'h00}; upd_c = 1'b1;
               end
               default: res = operand_ff;
            endcase
            if (opcode_latch_ff[9:6] != 4'h0) begin
               wr_file = opcode_latch_ff[5];
               wr_acc  = !opcode_latch_ff[5];
            end else if (opcode_latch_ff[5]) begin
               res = accum_ff; wr_file = 1'b1;
            end
         end
         4'ha, 4'hb: begin
            branch     = 1'b1;
            branch_tgt = opcode_latch_ff[IPTR_W-1:0];
         end
         4'hc: begin res = lit; wr_acc = 1'b1; end
         4'hd: begin res = accum_ff | lit; wr_acc = 1'b1; upd_z = 1'b1; end
         4'he: begin res = accum_ff & lit; wr_acc = 1'b1; upd_z = 1'b1; end
         4'hf: begin res = accum_ff ^ lit; wr_acc = 1'b1; upd_z = 1'b1; end
         default: ;
      endcase
   end

   always_comb begin
      nxt_accum   = accum_ff;
      nxt_flags   = flags_ff;
      nxt_fsp     = fsp_ff;
      nxt_trim    = trim_ff;
      nxt_timer   = timer_ff;
      nxt_io      = io_ff;
      nxt_operand = operand_ff;
      if (phase_ff == PHASE_TWO)
         nxt_operand = file_rd;
      if (phase_ff == PHASE_FOUR) begin
         if (wr_acc)
            nxt_accum = res;
         if (upd_z)
            nxt_flags[FLAG_ZERO] = (res == 8'h00);
         if (upd_c)
            nxt_flags[FLAG_CARRY] = sum[DATA_W];
         if (upd_h)
            nxt_flags[FLAG_HALF] = nib[4];
         if (wr_file) begin
            unique case (file_addr)
               ADDR_TIMER:    nxt_timer = res;
               ADDR_FLAGS:    nxt_flags = res;
               ADDR_FSP:      nxt_fsp   = res;
               ADDR_OSC_TRIM: nxt_trim  = res;
               ADDR_IO_PINS:  nxt_io    = res[5:0];
               default:       ;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         accum_ff   <= '0;
         flags_ff   <= FLAGS_RST;
         fsp_ff     <= '0;
         trim_ff    <= TRIM_RST;
         timer_ff   <= '0;
         io_ff      <= '0;
         operand_ff <= '0;
      end else begin
         accum_ff   <= nxt_accum;
         flags_ff   <= nxt_flags;
         fsp_ff     <= nxt_fsp;
         trim_ff    <= nxt_trim;
         timer_ff   <= nxt_timer;
         io_ff      <= nxt_io;
         operand_ff <= nxt_operand;
      end
   end

   // Memory array has no reset; software initialises general registers
   always_ff @(posedge clk_i) begin
      if (phase_ff == PHASE_FOUR && wr_file && file_addr >= ADDR_GPR_FIRST)
         gpr_mem[gpr_index(file_addr, fsp_ff)] <= res;
   end

   // ****************************************
   // Outputs
   // ****************************************
   qpc_osc_e osc_mode;
   assign osc_mode             = qpc_osc_e'(osc_mode_select_bits_i);
   assign crystal_ext_clk_ok_o = (osc_mode == LOW_POWER_CRYSTAL_MODE) ||
                                 (osc_mode == STANDARD_CRYSTAL_MODE);
   assign prog_addr_o          = iptr_ff;
   assign io_pins_o            = io_ff;
   // Only bits 1:0 are driven, and only during programming, so the serial pair owns them
   assign io_pins_oe_n_o       = prog_mode_i ? 6'h3c : 6'h3f;
   assign prog_data_pin_o      = io_ff[0];
   assign prog_clock_pin_o     = io_ff[1];
   assign phase_o              = phase_ff;
   assign accum_o              = accum_ff;
   assign core_flags_o         = flags_ff;

   // ****************************************
   // Assertions
   // ****************************************
   phase_cycle_a: assert property (@(posedge clk_i) disable iff (reset_i)
      phase_ff == PHASE_ONE |=> phase_ff == PHASE_TWO ##1 phase_ff == PHASE_THREE
      ##1 phase_ff == PHASE_FOUR ##1 phase_ff == PHASE_ONE)
      else $error("phase sequence broken");
   iptr_incr_a: assert property (@(posedge clk_i) disable iff (reset_i)
      phase_ff == PHASE_ONE |=> iptr_ff == $past(iptr_ff) + 1'b1)
      else $error("pointer not incremented");
   latch_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
      phase_ff != PHASE_ONE |=> $stable(opcode_latch_ff))
      else $error("opcode changed mid execution");
   operand_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
      phase_ff != PHASE_TWO |=> $stable(operand_ff))
      else $error("operand read outside phase two");
   branch_flush_a: assert property (@(posedge clk_i) disable iff (reset_i)
      phase_ff == PHASE_FOUR && branch |=> ##1 opcode_latch_ff == NOP_WORD)
      else $error("prefetch not discarded");
   branch_target_a: assert property (@(posedge clk_i) disable iff (reset_i)
      phase_ff == PHASE_FOUR && branch |=> iptr_ff + 1'b1 == $past(branch_tgt)
      ##1 iptr_ff == $past(branch_tgt, 2))
      else $error("branch target not fetched");
   accum_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
      phase_ff != PHASE_FOUR |=> $stable(accum_ff))
      else $error("accumulator written outside phase four");
   zero_flag_a: assert property (@(posedge clk_i) disable iff (reset_i)
      phase_ff == PHASE_FOUR && upd_z && !wr_file
      |=> flags_ff[FLAG_ZERO] == ($past(res) == 8'h00))
      else $error("zero flag wrong");
   fetch_cov: cover property (@(posedge clk_i) disable iff (reset_i)
      phase_ff == PHASE_FOUR && !branch);
   branch_cov: cover property (@(posedge clk_i) disable iff (reset_i)
      phase_ff == PHASE_FOUR && branch);
   bank_cov: cover property (@(posedge clk_i) disable iff (reset_i)
      wr_file && file_addr >= ADDR_BANKED && fsp_ff[6:5] == 2'h1);
endmodule

// ===== qpc_pkg.sv
// Package: constants and types for the quad phase core pipeline
package qpc_pkg;
   // Register file map
   localparam logic [4:0] ADDR_INDIRECT  = 5'h00;
   localparam logic [4:0] ADDR_TIMER     = 5'h01;
   localparam logic [4:0] ADDR_IPTR_LOW  = 5'h02;
   localparam logic [4:0] ADDR_FLAGS     = 5'h03;
   localparam logic [4:0] ADDR_FSP       = 5'h04;
   localparam logic [4:0] ADDR_OSC_TRIM  = 5'h05;
   localparam logic [4:0] ADDR_IO_PINS   = 5'h06;
   localparam logic [4:0] ADDR_GPR_FIRST = 5'h07;
   localparam logic [4:0] ADDR_BANKED    = 5'h10;
   localparam int         GPR_WORDS      = 57;
   localparam logic [5:0] BANK_OFFSET    = 6'h20;
   localparam int         FSP_BANK_LSB   = 5;
   // Flag bit positions
   localparam int FLAG_CARRY = 0;
   localparam int FLAG_HALF  = 1;
   localparam int FLAG_ZERO  = 2;
   // Widths
   localparam int OPC_W  = 12;
   localparam int DATA_W = 8;
   localparam int IPTR_W = 9;
   // Reset values
   localparam logic [11:0] NOP_WORD   = 12'h000;
   localparam logic [7:0]  FLAGS_RST  = 8'h18;
   localparam logic [7:0]  TRIM_RST   = 8'h80;
   localparam logic [8:0]  IPTR_RST   = 9'h1ff;
   // Oscillator modes
   typedef enum logic [1:0] {
      LOW_POWER_CRYSTAL_MODE = 2'h0,
      STANDARD_CRYSTAL_MODE  = 2'h1,
      INTERNAL_RC_MODE       = 2'h2,
      EXTERNAL_RC_MODE       = 2'h3
   } qpc_osc_e;
   typedef enum logic [1:0] {PHASE_ONE, PHASE_TWO, PHASE_THREE, PHASE_FOUR} qpc_phase_e;
endpackage

// ===== qpc_prog_mem.sv
// Program memory model standing on the far side of the core's program bus
`timescale 1ns/100ps
// ********************
// Program store
// ********************
module qpc_prog_mem
   import qpc_pkg::*;
(
   input  wire logic [IPTR_W-1:0] addr_i,
   output logic      [OPC_W-1:0]  data_o
);
   logic [OPC_W-1:0] word_mem [0:511];

   // Whole word in one read on its own bus; data memory never shares it
   assign data_o = word_mem[addr_i];
endmodule

// ===== quad_phase_core_pipeline_tb.sv
// Self-checking testbench for the quad phase core pipeline
`timescale 1ns/100ps
module quad_phase_core_pipeline_tb
   import qpc_pkg::*;
;
   // ********************
   // Signals and instances
   // ********************
   logic              clk_i;
   logic              reset_i;
   logic [IPTR_W-1:0] prog_addr;
   logic [OPC_W-1:0]  prog_data;
   logic [1:0]        osc_mode;
   logic              prog_mode;
   logic [5:0]        io_in;
   logic [5:0]        io_out;
   logic [5:0]        io_oe_n;
   logic              pdata_pin;
   logic              pclk_pin;
   logic              ext_ok;
   logic [1:0]        phase;
   logic [DATA_W-1:0] accum;
   logic [DATA_W-1:0] flags;
   logic [11:0]       prog[$];
   int                n_fail;
   int                samples_checked;

   qpc_core u_qpc_core (
      .clk_i                  (clk_i),
      .reset_i                (reset_i),
      .prog_addr_o            (prog_addr),
      .prog_data_i            (prog_data),
      .osc_mode_select_bits_i (osc_mode),
      .prog_mode_i            (prog_mode),
      .io_pins_i              (io_in),
      .io_pins_o              (io_out),
      .io_pins_oe_n_o         (io_oe_n),
      .prog_data_pin_o        (pdata_pin),
      .prog_clock_pin_o       (pclk_pin),
      .crystal_ext_clk_ok_o   (ext_ok),
      .phase_o                (phase),
      .accum_o                (accum),
      .core_flags_o           (flags)
   );

   qpc_prog_mem u_qpc_prog_mem (
      .addr_i (prog_addr),
      .data_o (prog_data)
   );

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   // ********************
   // Shared tasks
   // ********************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic fill_and_reset();
      for (int i = 0; i < 512; i++) begin
         u_qpc_prog_mem.word_mem[i] = (i < prog.size()) ? prog[i] : NOP_WORD;
      end
      @(negedge clk_i);
      reset_i = 1'b1;
      repeat (8) @(negedge clk_i);
      reset_i = 1'b0;
   endtask

   // Word 0 stays a no-op; a jump to itself parks the core once done
   task automatic run_prog();
      prog.push_front(NOP_WORD);
      prog.push_back(12'ha00 | 12'(prog.size()));
      fill_and_reset();
      repeat (4 * (prog.size() + 3)) @(negedge clk_i);
   endtask

   task automatic alu_check(input logic [7:0] w, input logic [2:0] f);
      check(16'(accum), 16'(w));
      check(16'(flags[2:0]), 16'(f));
   endtask

   // ********************
   // Scenarios
   // ********************
   task automatic test_reset_phases();
      prog = {};
      fill_and_reset();
      // Let the core run so the mid-run reset has live state to clear
      repeat (6) @(negedge clk_i);
      reset_i = 1'b1;
      repeat (2) @(negedge clk_i);
      check(16'(prog_addr), 16'(IPTR_RST));
      check(16'(phase), 16'h0);
      check(16'(accum), 16'h0);
      check(16'(flags), 16'(FLAGS_RST));
      reset_i = 1'b0;
      // Pointer steps on the edge leaving phase one, so it trails the phase count
      for (int k = 1; k <= 12; k++) begin
         @(negedge clk_i);
         check(16'(phase), 16'(k % 4));
         check(16'(prog_addr), 16'((k - 1) / 4));
      end
      $display("test_reset_phases done");
   endtask

   task automatic test_alu();
      prog = '{12'hc0f, 12'h027, 12'hcf1, 12'h1c7};
      run_prog();
      alu_check(8'h00, 3'b111);
      prog = '{12'hc05, 12'h027, 12'hc03, 12'h087};
      run_prog();
      alu_check(8'h02, 3'b011);
      prog = '{12'hc17, 12'h027, 12'hcd9, 12'h087};
      run_prog();
      alu_check(8'h3e, 3'b000);
      prog = '{12'hc5a, 12'h027, 12'hcff, 12'h187, 12'h147};
      run_prog();
      alu_check(8'h00, 3'b100);
      prog = '{12'hce6, 12'h027, 12'h347};
      run_prog();
      alu_check(8'hcc, 3'b001);
      // Rotate right, or into file, complement, and-literal, xor-literal as one chain
      prog = '{12'hc81, 12'h027, 12'h307, 12'h127, 12'h247, 12'he3c, 12'hf3d};
      run_prog();
      alu_check(8'h01, 3'b001);
      prog = '{12'hc55, 12'h027, 12'h067, 12'h207};
      run_prog();
      alu_check(8'h00, 3'b100);
      $display("test_alu done");
   endtask

   task automatic test_branch();
      // The word after the jump would OR in 11h if it were not flushed
      prog = '{12'ha06, 12'hd11, 12'h000, 12'h000, 12'h000, 12'hd22};
      run_prog();
      check(16'(accum), 16'h0022);
      check(16'(prog_addr), 16'h0007);
      $display("test_branch done");
   endtask

   task automatic test_banks();
      prog = '{12'hc00, 12'h024, 12'hc11, 12'h030, 12'hc20, 12'h024, 12'hc22,
               12'h030, 12'hc09, 12'h027, 12'hc00, 12'h024, 12'h210};
      run_prog();
      check(16'(accum), 16'h0011);
      // Write 07h in the first bank, then read it back through the second
      prog = '{12'hc09, 12'h027, 12'hc20, 12'h024, 12'hc22, 12'h030, 12'h207,
               12'h1d0};
      run_prog();
      check(16'(accum), 16'h002b);
      prog = '{12'hc08, 12'h024, 12'hc5c, 12'h020, 12'hc00, 12'h208};
      run_prog();
      check(16'(accum), 16'h005c);
      $display("test_banks done");
   endtask

   task automatic test_io_osc();
      prog_mode = 1'b1;
      io_in     = 6'h2d;
      prog = '{12'hc02, 12'h026, 12'h206};
      run_prog();
      check(16'(io_out), 16'h0002);
      check(16'(accum), 16'h002d);
      check(16'({pclk_pin, pdata_pin}), 16'h0002);
      check(16'(io_oe_n), 16'h003c);
      for (int m = 0; m < 4; m++) begin
         osc_mode = 2'(m);
         @(negedge clk_i);
         check(16'(ext_ok), 16'(m < 2));
      end
      prog_mode = 1'b0;
      @(negedge clk_i);
      check(16'(io_oe_n), 16'h003f);
      $display("test_io_osc done");
   endtask

   // ********************
   // Closing and main sequence
   // ********************
   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      n_fail          = 0;
      samples_checked = 0;
      reset_i         = 1'b1;
      osc_mode        = 2'h1;
      prog_mode       = 1'b0;
      io_in           = 6'h00;
      repeat (8) @(negedge clk_i);
      test_reset_phases();
      test_alu();
      test_branch();
      test_banks();
      test_io_osc();
      report_and_stop();
   end
endmodule
